// ---- pldmc_array.sv ----
// Programmable AND array: one product per term over true and complement literals
`default_nettype none
module pldmc_array
  import pldmc_pkg::*;
(
  input  wire logic [NLIT-1:0]            lits,   // Current literal values
  input  wire logic [NTERM-1:0][NLIT-1:0] tmask,  // Connected true literals
  input  wire logic [NTERM-1:0][NLIT-1:0] cmask,  // Connected complement literals
  output logic      [NTERM-1:0]           terms   // Product term values
);
  // Unconnected literals count as one; true and complement together give zero
  always_comb begin
    for (int t = 0; t < NTERM; t++) begin
      terms[t] = (&(~tmask[t] | lits)) & (&(~cmask[t] | ~lits));
    end
  end
endmodule : pldmc_array
`default_nettype wire

// ---- pldmc_board.sv ----
// Board model: pad level of each cell pin
`default_nettype none
module pldmc_board
  import pldmc_pkg::*;
(
  input  wire logic             aclk,     // Clock
  input  wire logic [NCELL-1:0] dev_out,  // Device value
  input  wire logic [NCELL-1:0] dev_oe,   // Device enable
  input  wire logic [NCELL-1:0] tst_out,  // Tester value
  input  wire logic [NCELL-1:0] tst_oe,   // Tester enable
  output logic      [NCELL-1:0] pad       // Pad level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NCELL-1:0] held = '0;  // Bus hold keeps a released pad at its last level
  // Tester drives registered pins only in preload, others float on bus hold
  assign pad = (dev_oe & dev_out) | (tst_oe & tst_out) | (~dev_oe & ~tst_oe & held);
  // Latch of the bus hold
  always @(posedge aclk) held <= pad;
endmodule : pldmc_board
`default_nettype wire

// ---- pldmc_cell_top.sv ----
// Ten output macro cells with their array, preload mode and register slave
// Behaviour
// - Each pin three-state, enabled by its term
// - Combinatorial pin is bidirectional, registered pin is output only
// - Polarity bit inverts both path kinds alike
// - Polarity one passes value, zero inverts it
// - Preset term loads ones at clock edge
// - Reset term clears flip-flops without clock edge
// - Preset and reset act on flop, not pin
// - Flip-flops clear to zero at power-up
// - Power-up clear done within delay window
// - Secured device reads back all fuses programmed; code hides only the term mask words, polarity and path still read true
// - Super-level preload input disables all outputs
// - Flops capture sum on dedicated clock rise
// - Path zero registered, feedback from inverted flop
// - Path one bypasses flop, feedback from pin
// - Empty term is one, contradiction is zero
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module pldmc_cell_top
  import pldmc_pkg::*;
(
  input  wire logic              aclk,                  // System clock, 20 MHz
  input  wire logic              aresetn,               // Synchronous reset, low active
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,          // Write address
  input  wire logic [2:0]        s_axi_awprot,          // Write protection, unused
  input  wire logic              s_axi_awvalid,         // Write address valid
  output logic                   s_axi_awready,         // Write address ready
  input  wire logic [31:0]       s_axi_wdata,           // Write data
  input  wire logic [3:0]        s_axi_wstrb,           // Write byte strobes
  input  wire logic              s_axi_wvalid,          // Write data valid
  output logic                   s_axi_wready,          // Write data ready
  output logic [1:0]             s_axi_bresp,           // Write response
  output logic                   s_axi_bvalid,          // Write response valid
  input  wire logic              s_axi_bready,          // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,          // Read address
  input  wire logic [2:0]        s_axi_arprot,          // Read protection, unused
  input  wire logic              s_axi_arvalid,         // Read address valid
  output logic                   s_axi_arready,         // Read address ready
  output logic [31:0]            s_axi_rdata,           // Read data
  output logic [1:0]             s_axi_rresp,           // Read response
  output logic                   s_axi_rvalid,          // Read data valid
  input  wire logic              s_axi_rready,          // Read data ready
  input  wire logic              clock_or_input_zero,   // Dedicated clock pin, also input 0
  input  wire logic [NDED-1:0]   dedicated_in,          // Dedicated inputs 1 to 11
  input  wire logic              super_level_voltage,   // Preload super-level detected
  input  wire logic [NCELL-1:0]  cell_pins_in,          // Cell pin levels seen at the pad
  output logic [NCELL-1:0]       cell_pins_out,         // Cell pin drive value
  output logic [NCELL-1:0]       cell_pins_oe,          // Cell pin drive enable, high drives
  output logic                   regs_ready             // Power-up clear complete
);
  pldmc_state_t s;                                      // Registered state
  pldmc_state_t next_s;                                 // Next state
  logic [SYNC_W-1:0] pins_sync;                         // Synchronised pins
  logic              clk_pin_s;                         // Synchronised dedicated clock
  logic [NDED-1:0]   ded_s;                             // Synchronised dedicated inputs
  logic [NCELL-1:0]  cell_s;                            // Synchronised cell pins
  logic              preload_s;                         // Synchronised super-level flag
  logic [NLIT-1:0]   lits;                              // Array literals
  logic [NTERM-1:0]  terms;                             // Array outputs
  logic [NCELL-1:0]  sop;                               // Per-cell sum value
  logic [NCELL-1:0]  oe_terms;                          // Per-cell enable terms
  logic              term_sp;                           // Global preset term
  logic              term_ar;                           // Global reset term
  logic              tick;                              // Rising edge of dedicated clock
  logic [31:0]       wr_old;                            // Current word at write address
  logic [31:0]       wr_new;                            // Word after byte strobes
  logic [31:0]       rd_word;                           // Word at read address

  // Byte-lane merge for strobed writes
  function automatic logic [31:0] pldmc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : pldmc_merge

  // True when the address falls into the term mask window
  function automatic logic pldmc_term_hit(input logic [ADDR_W-1:0] a);
    return (a >= REG_TERM_BASE) && (a < REG_TERM_END);
  endfunction : pldmc_term_hit

  // Word-aligned form of an address
  function automatic logic [ADDR_W-1:0] pldmc_align(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'h0};
  endfunction : pldmc_align

  // True for any decoded register
  function automatic logic pldmc_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = pldmc_align(a);
    return (w == REG_POLARITY) || (w == REG_PATH) || (w == REG_SECURITY) ||
           (w == REG_STATUS) || (w == REG_FLOPS) || pldmc_term_hit(a);
  endfunction : pldmc_mapped

  // Register read value; hide masks the term mask words once secured
  function automatic logic [31:0] pldmc_reg_value(input pldmc_state_t st,
                                                  input logic [ADDR_W-1:0] a,
                                                  input logic hide);
    logic [ADDR_W-1:0] w;
    logic [4:0]        t;
    logic [31:0]       v;
    w = pldmc_align(a);
    t = a[TERM_IDX_LSB +: 5];
    v = 32'h0000_0000;
    if (w == REG_POLARITY) begin
      v = 32'(st.polarity);
    end else if (w == REG_PATH) begin
      v = 32'(st.path);
    end else if (w == REG_SECURITY) begin
      v = 32'(st.secure);
    end else if (w == REG_STATUS) begin
      v[STAT_READY_BIT]   = st.ready;
      v[STAT_PRELOAD_BIT] = (st.pl_cnt != '0);
    end else if (w == REG_FLOPS) begin
      v = 32'(st.q);
    end else if (pldmc_term_hit(a)) begin
      // Secured readback shows every fuse as programmed
      if (hide) begin
        v = 32'(MASK_ALL);
      end else if (a[TERM_CMP_BIT]) begin
        v = 32'(st.cmask[t]);
      end else begin
        v = 32'(st.tmask[t]);
      end
    end
    return v;
  endfunction : pldmc_reg_value

  // Every pin passes two flops before any logic looks at it
  pldmc_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pins_in  ({super_level_voltage, cell_pins_in, dedicated_in, clock_or_input_zero}),
    .pins_out (pins_sync)
  );

  assign clk_pin_s = pins_sync[0];
  assign ded_s     = pins_sync[NDED:1];
  assign cell_s    = pins_sync[NCELL+NDED:NDED+1];
  assign preload_s = pins_sync[SYNC_W-1];

  // Feedback per cell: inverted flop when registered, pin when combinatorial
  always_comb begin
    lits              = '0;
    lits[0]           = clk_pin_s;
    lits[LIT_DED_LSB +: NDED] = ded_s;
    for (int i = 0; i < NCELL; i++) begin
      lits[LIT_FB_LSB + i] = s.path[i] ? cell_s[i] : ~s.q[i];
    end
  end

  // Product terms of all cells
  pldmc_array u_array (
    .lits  (lits),
    .tmask (s.tmask),
    .cmask (s.cmask),
    .terms (terms)
  );

  assign sop      = terms[NCELL-1:0];
  assign oe_terms = terms[TERM_OE_BASE +: NCELL];
  assign term_sp  = terms[TERM_SP];
  assign term_ar  = terms[TERM_AR];
  // Clock edges count only once the power-up clear is over
  assign tick     = clk_pin_s && !s.clk_prev && s.ready;
  assign wr_old   = pldmc_reg_value(s, s.aw_addr, 1'b0);
  assign wr_new   = pldmc_merge(wr_old, s.w_data, s.w_strb);
  assign rd_word  = pldmc_reg_value(s, s_axi_araddr, s.secure);

  // Next-state logic for bus slave, cells and housekeeping
  always_comb begin
    next_s = s;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // Both halves present: commit and answer
    if (s.aw_have && s.w_have && !s.bvalid) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = pldmc_mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (pldmc_align(s.aw_addr) == REG_POLARITY) begin
        next_s.polarity = wr_new[NCELL-1:0];
      end else if (pldmc_align(s.aw_addr) == REG_PATH) begin
        next_s.path = wr_new[NCELL-1:0];
      end else if (pldmc_align(s.aw_addr) == REG_SECURITY) begin
        // Security is one-way until the next reset
        next_s.secure = s.secure | wr_new[SECURE_BIT];
      end else if (pldmc_term_hit(s.aw_addr)) begin
        if (s.aw_addr[TERM_CMP_BIT]) begin
          next_s.cmask[s.aw_addr[TERM_IDX_LSB +: 5]] = wr_new[NLIT-1:0];
        end else begin
          next_s.tmask[s.aw_addr[TERM_IDX_LSB +: 5]] = wr_new[NLIT-1:0];
        end
      end
    end
    // Read channel: one outstanding read
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word;
      next_s.rresp  = pldmc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready  = !next_s.w_have && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // Power-up delay counter; flops stay clear until it expires
    if (s.por_cnt != POR_W'(POR_CYCLES)) begin
      next_s.por_cnt = s.por_cnt + POR_W'(1);
    end
    next_s.ready    = (next_s.por_cnt == POR_W'(POR_CYCLES));
    next_s.clk_prev = clk_pin_s;

    // Outputs stay off briefly after the super-level drops
    if (preload_s) begin
      next_s.pl_cnt = PL_W'(PL_CYCLES);
    end else if (s.pl_cnt != '0) begin
      next_s.pl_cnt = s.pl_cnt - PL_W'(1);
    end

    // Flop update: reset term first, then clocked preload, preset, capture
    for (int i = 0; i < NCELL; i++) begin
      if (term_ar) begin
        next_s.q[i] = 1'b0;
      end else if (tick && preload_s) begin
        // Only registered cells take the pin value
        if (!s.path[i]) begin
          next_s.q[i] = cell_s[i];
        end
      end else if (tick && term_sp) begin
        next_s.q[i] = 1'b1;
      end else if (tick) begin
        next_s.q[i] = sop[i];
      end
    end

    // Pin value through polarity; preset and reset reach the pin only via q
    for (int i = 0; i < NCELL; i++) begin
      next_s.pin_out[i] = (next_s.path[i] ? sop[i] : next_s.q[i])
                          ^ ~next_s.polarity[i];
    end
    // Enable term drives the buffer; a never-true term leaves an input pin
    next_s.pin_oe = (preload_s || s.pl_cnt != '0) ? '0 : oe_terms;
  end

  // State register; reset gives the power-up clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.pin_out  <= ~POLARITY_RST;                        // Cleared flop seen through polarity
      s.polarity <= POLARITY_RST;
      s.path     <= PATH_RST;
      s.tmask    <= {NTERM{MASK_RST}};
      s.cmask    <= {NTERM{MASK_RST}};
      s.bresp    <= RESP_OKAY;
      s.rresp    <= RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;
  assign cell_pins_out = s.pin_out;
  assign cell_pins_oe  = s.pin_oe;
  assign regs_ready    = s.ready;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Preload forces every buffer off
  oe_off_preload_a: assert property (preload_s |=> cell_pins_oe == '0)
    else $error("outputs enabled during preload");

  // Enable follows its term outside preload
  oe_follows_term_a: assert property ((!preload_s && s.pl_cnt == '0)
    |=> cell_pins_oe == $past(oe_terms))
    else $error("output enable does not follow its term");

  // Reset term clears and wins over preset
  reset_clears_a: assert property (term_ar |=> s.q == '0)
    else $error("reset term did not clear flops");

  // Preset loads ones on a clock edge
  preset_sets_a: assert property ((tick && !term_ar && !preload_s && term_sp)
    |=> s.q == '1)
    else $error("preset term did not set flops");

  // Normal capture of the sum value
  sum_capture_a: assert property ((tick && !term_ar && !preload_s && !term_sp)
    |=> s.q == $past(sop))
    else $error("flops did not capture sum");

  // Registered pins show q through polarity
  reg_polarity_a: assert property (((cell_pins_out ^ ~s.polarity) & ~s.path)
    == (s.q & ~s.path))
    else $error("registered pin polarity wrong");

  // Combinatorial pins show the sum through polarity
  comb_polarity_a: assert property (1'b1 |=> ((cell_pins_out ^ ~s.polarity) & s.path)
    == ($past(sop) & s.path))
    else $error("combinatorial pin polarity wrong");

  // Preload loads registered cells from their pins
  preload_load_a: assert property ((tick && !term_ar && preload_s)
    |=> (s.q & ~$past(s.path)) == ($past(cell_s) & ~$past(s.path)))
    else $error("preload did not load pins");

  // Flops hold zero until power-up clear finishes
  powerup_zero_a: assert property (!s.ready |-> s.q == '0)
    else $error("flop nonzero before ready");

  // Ready rises exactly when the delay count is reached
  ready_time_a: assert property ($rose(s.ready)
    |-> s.por_cnt == POR_W'(POR_CYCLES) && $past(s.por_cnt) == POR_W'(POR_CYCLES - 1))
    else $error("ready timing wrong");

  // Secured term readback returns all ones
  secure_read_a: assert property ((s_axi_arvalid && s.arready && s.secure
    && pldmc_term_hit(s_axi_araddr)) |=> s_axi_rdata == 32'(MASK_ALL))
    else $error("secured readback leaked pattern");
endmodule : pldmc_cell_top
`default_nettype wire

// ---- pldmc_pkg.sv ----
// Shared constants, register map and state types of the output macro cell block
`default_nettype none
package pldmc_pkg;
  // Clock and array geometry
  localparam int CLK_PERIOD_NS = 50;                 // 20 MHz system clock
  localparam int NCELL         = 10;                 // Output cells
  localparam int NDED          = 11;                 // Dedicated inputs beside the clock pin
  localparam int NLIT          = 22;                 // Array literals: clock pin, inputs, feedback
  localparam int NTERM         = 22;                 // Sum, enable, preset and reset terms
  localparam int LIT_DED_LSB   = 1;                  // First dedicated input literal
  localparam int LIT_FB_LSB    = 12;                 // First feedback literal
  localparam int TERM_OE_BASE  = 10;                 // First output enable term
  localparam int TERM_SP       = 20;                 // Global synchronous preset term
  localparam int TERM_AR       = 21;                 // Global asynchronous reset term
  localparam int SYNC_W        = 23;                 // Pins passing the synchroniser
  localparam int ADDR_W        = 12;                 // Register bus address width

  // Timing: power-up clear window and preload exit delay
  localparam int RESET_DELAY_MIN_NS = 1000;
  localparam int RESET_DELAY_MAX_NS = 10000;
  localparam int POR_CYCLES = (RESET_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_MAX_CYCLES = RESET_DELAY_MAX_NS / CLK_PERIOD_NS;
  localparam int PRELOAD_IO_NS = 100;
  localparam int PL_CYCLES = (PRELOAD_IO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W = 8;                          // Holds POR_CYCLES
  localparam int PL_W  = 2;                          // Holds PL_CYCLES

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_POLARITY  = 12'h000;
  localparam logic [ADDR_W-1:0] REG_PATH      = 12'h004;
  localparam logic [ADDR_W-1:0] REG_SECURITY  = 12'h008;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_FLOPS     = 12'h010;
  localparam logic [ADDR_W-1:0] REG_TERM_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] REG_TERM_END  = 12'h1B0;
  localparam int TERM_IDX_LSB = 3;                   // Eight bytes per term
  localparam int TERM_CMP_BIT = 2;                   // Set: complement mask word

  // Field positions and reset values
  localparam int SECURE_BIT       = 0;
  localparam int STAT_READY_BIT   = 0;
  localparam int STAT_PRELOAD_BIT = 1;
  localparam logic [NCELL-1:0] POLARITY_RST = 10'h000;
  localparam logic [NCELL-1:0] PATH_RST     = 10'h000;
  localparam logic [NLIT-1:0]  MASK_RST     = 22'h3F_FFFF;
  localparam logic [NLIT-1:0]  MASK_ALL     = 22'h3F_FFFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Synchroniser state
  typedef struct packed {
    logic [SYNC_W-1:0] meta;                         // First stage, read only by second
    logic [SYNC_W-1:0] stable;                       // Second stage
  } pldmc_sync_t;

  // Whole state of the top module
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic aw_have, w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [NCELL-1:0] polarity, path, q, pin_out, pin_oe;
    logic secure, clk_prev, ready;
    logic [POR_W-1:0] por_cnt;
    logic [PL_W-1:0] pl_cnt;
    logic [NTERM-1:0][NLIT-1:0] tmask, cmask;
  } pldmc_state_t;
endpackage : pldmc_pkg
`default_nettype wire

// ---- pldmc_sync.sv ----
// Two-stage synchroniser for all pin inputs
`default_nettype none
module pldmc_sync
  import pldmc_pkg::*;
(
  input  wire logic              aclk,     // System clock
  input  wire logic              aresetn,  // Synchronous reset, low active
  input  wire logic [SYNC_W-1:0] pins_in,  // Raw pin levels
  output logic      [SYNC_W-1:0] pins_out  // Synchronised levels
);
  pldmc_sync_t s;                          // Registered state
  pldmc_sync_t next_s;                     // Next state

  // Shift one stage per clock
  always_comb begin
    next_s        = s;
    next_s.meta   = pins_in;
    next_s.stable = s.meta;
  end

  // Register with synchronous clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pins_out = s.stable;
endmodule : pldmc_sync
`default_nettype wire

// ---- tb_pld_output_macro_cell.sv ----
// Bench: bus, preset, reset, path and preload scenarios of the cell block
`default_nettype none
module tb_pld_output_macro_cell
  import pldmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;  // Bus controls
  logic awr, wr, bv, arr, rv, rdy, ck = 0, sup = 0;  // Answers, clock pin, preload
  logic [ADDR_W-1:0] awa = '0, ara = '0;  // Addresses
  logic [31:0] wd = '0, rd;  // Data
  logic [1:0] br, rr;  // Responses
  logic [NCELL-1:0] po, poe, pad, tv = '0, toe = '0;  // Pin wires
  int failures = 0, total_checks = 0;  // Tallies
  always #25 aclk = ~aclk;  // 20 MHz
  pldmc_cell_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .clock_or_input_zero(ck),
    .dedicated_in(11'h000), .super_level_voltage(sup), .cell_pins_in(pad),
    .cell_pins_out(po), .cell_pins_oe(poe), .regs_ready(rdy));
  pldmc_board i_board (.aclk(aclk), .dev_out(po), .dev_oe(poe), .tst_out(tv),
    .tst_oe(toe), .pad(pad));
  // Compare and tally
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // A used-up wait bound counts as a mismatch
  task automatic tmo(input int n);
    if (n >= 99) begin
      failures++;
      print_verdict();
    end
  endtask : tmo
  // Write one word, address and data offered together
  task automatic wr32(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= '1;
    wv <= '1;
    bry <= '1;
    do begin
      @(posedge aclk);
      if (awr) awv <= '0;
      if (wr) wv <= '0;
      n++;
    end while (!bv && n < 99);
    bry <= '0;
    tmo(n);
    chk("bresp", 32'(br), 32'(er));
  endtask : wr32
  // Read one word and judge data and response
  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= '1;
    rry <= '1;
    do begin
      @(posedge aclk);
      if (arr) arv <= '0;
      n++;
    end while (!rv && n < 99);
    rry <= '0;
    tmo(n);
    chk(nm, rd, e);
    chk(nm, 32'(rr), 32'(er));
  endtask : rchk
  // Clock pin pulse, long enough for the synchroniser
  task automatic tick();
    ck <= '1;
    repeat (3) @(posedge aclk);
    ck <= '0;
    repeat (4) @(posedge aclk);
  endtask : tick
  // Power-up clear, then an idle bus answering unmapped addresses
  task automatic sc_powerup();
    repeat (18) @(posedge aclk);
    chk("ready early", 32'(rdy), 32'h0);
    repeat (4) @(posedge aclk);
    chk("ready", 32'(rdy), 32'h1);
    rchk("flops", REG_FLOPS, 32'h0, RESP_OKAY);
    rchk("unmapped", 12'h020, 32'h0, RESP_SLVERR);
    wr32(12'h020, 32'h1, RESP_SLVERR);
    chk("oe idle", 32'(poe), 32'h0);
  endtask : sc_powerup
  // Preset term and output polarity
  task automatic sc_preset();
    wr32(12'h1A0, 32'h0);  // Empty preset term is true
    wr32(12'h1A4, 32'h0);
    wr32(12'h150, 32'h0);  // Cell 0 enable always on
    wr32(12'h154, 32'h0);
    wr32(REG_POLARITY, 32'h1);
    tick();
    rchk("preset", REG_FLOPS, 32'h0000_03FF, RESP_OKAY);
    chk("pin high", 32'({po[0], poe[1:0]}), 32'h5);
    wr32(REG_POLARITY, 32'h0);
    tick();
    chk("pin inverted", 32'(po[0]), 32'h0);
  endtask : sc_preset
  // Reset term clears at once and beats the preset term
  task automatic sc_reset_term();
    wr32(12'h1A8, 32'h0);  // Reset term true beside preset
    wr32(12'h1AC, 32'h0);
    rchk("async clear", REG_FLOPS, 32'h0, RESP_OKAY);
    tick();
    rchk("reset wins", REG_FLOPS, 32'h0, RESP_OKAY);
    chk("pin cleared", 32'(po[0]), 32'h1);
    wr32(12'h1A8, 32'h003F_FFFF);  // Reset term false again
  endtask : sc_reset_term
  // Combinatorial cell shows its sum through polarity
  task automatic sc_comb();
    wr32(12'h100, 32'h0);  // Cell 0 sum true
    wr32(12'h104, 32'h0);
    wr32(REG_PATH, 32'h1);
    wr32(REG_POLARITY, 32'h1);
    repeat (3) @(posedge aclk);
    chk("comb pin", 32'(po[0]), 32'h1);
  endtask : sc_comb
  // Preload from the pins, then check through polarity after exit
  task automatic sc_preload();
    sup <= '1;
    repeat (4) @(posedge aclk);
    chk("preload oe", 32'(poe), 32'h0);
    tv <= 10'h2AA;
    toe <= 10'h3FE;  // Registered pins only, cell 0 floats
    tick();
    toe <= '0;  // Release pins, then leave preload
    @(posedge aclk);
    sup <= '0;
    repeat (3) @(posedge aclk);  // More than 100 ns before trusting outputs
    rchk("preload", REG_FLOPS, 32'h0000_02AA, RESP_OKAY);
    chk("preload pins", 32'(po[9:1]), 32'h0000_00AA);
  endtask : sc_preload
  // Registered feedback is the inverted flop, so cell 1 toggles per clock
  task automatic sc_feedback();
    wr32(12'h1A0, 32'h003F_FFFF);  // Preset term false again
    wr32(12'h108, 32'h0000_2000);  // Cell 1 sum is its own feedback literal
    wr32(12'h10C, 32'h0);
    tick();
    rchk("toggle low", REG_FLOPS, 32'h0000_0001, RESP_OKAY);
    tick();
    rchk("toggle high", REG_FLOPS, 32'h0000_0003, RESP_OKAY);
  endtask : sc_feedback
  // Secured device hides the mask pattern
  task automatic sc_secure();
    wr32(REG_SECURITY, 32'h1);
    rchk("secured", 12'h100, 32'h003F_FFFF, RESP_OKAY);
  endtask : sc_secure
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= '1;
    sc_powerup();
    sc_preset();
    sc_reset_term();
    sc_comb();
    sc_preload();
    sc_feedback();
    sc_secure();
    print_verdict();
  end
endmodule : tb_pld_output_macro_cell
`default_nettype wire
